// *** iep_ctrl.v ***
`timescale 1ns/1ps
`default_nettype none
`include "iep_map.vh"

module iep_ctrl
(
	// Clock and reset
	input  wire                   sys_clk,
	input  wire                   rst,
	// AXI4-Lite write address
	input  wire [`IEP_ADDR_W-1:0] s_axi_awaddr,
	input  wire                   s_axi_awvalid,
	output wire                   s_axi_awready,
	// AXI4-Lite write data
	input  wire [31:0]            s_axi_wdata,
	input  wire [3:0]             s_axi_wstrb,
	input  wire                   s_axi_wvalid,
	output wire                   s_axi_wready,
	// AXI4-Lite write response
	output reg  [1:0]             s_axi_bresp,
	output reg                    s_axi_bvalid,
	input  wire                   s_axi_bready,
	// AXI4-Lite read address
	input  wire [`IEP_ADDR_W-1:0] s_axi_araddr,
	input  wire                   s_axi_arvalid,
	output wire                   s_axi_arready,
	// AXI4-Lite read data
	output reg  [31:0]            s_axi_rdata,
	output reg  [1:0]             s_axi_rresp,
	output reg                    s_axi_rvalid,
	input  wire                   s_axi_rready,
	// Peripheral requests, same clock; masks for the first six live elsewhere
	input  wire [`IEP_NSRC-1:0]   src_req,
	// Core handshake, same clock
	input  wire                   core_ack,
	input  wire                   core_reti,
	// Toward the core
	output reg                    core_irq,
	output reg  [2:0]             core_irq_src,
	output reg                    core_irq_high,
	output reg  [`IEP_NSRC-1:0]   src_high,
	// Event interrupt
	output wire                   irq
);
	reg  [7:0]             ext_irq_priority_1;
	reg  [1:0]             ext_irq_enable_2;
	reg  [1:0]             ext_irq_priority_2;
	reg  [`IEP_NEV-1:0]    ev_status;
	reg  [`IEP_NEV-1:0]    ev_mask;
	reg                    svc_lo;
	reg                    svc_hi;

	reg  [`IEP_ADDR_W-1:0] aw_addr;
	reg                    aw_held;
	reg  [31:0]            w_data;
	reg  [3:0]             w_strb;
	reg                    w_held;

	wire [`IEP_NSRC-1:0]   level_map;
	wire [`IEP_NSRC-1:0]   live_req;
	wire [`IEP_NSRC-1:0]   hi_req;
	wire [`IEP_NSRC-1:0]   lo_req;
	wire                   hi_hit;
	wire                   lo_hit;
	wire [2:0]             hi_idx;
	wire [2:0]             lo_idx;
	reg                    next_irq;
	reg  [2:0]             next_src;
	reg                    next_high;
	reg  [`IEP_NEV-1:0]    ev_set;

	wire [7:0]             w_idx;
	wire [7:0]             r_idx;
	wire                   do_write;
	wire                   do_read;
	wire                   w_ok;
	reg  [31:0]            rd_word;
	reg                    rd_ok;

	// Per-source level from the priority bits
	assign level_map[`IEP_SRC_TWOWIRE]    = ext_irq_priority_1[`IEP_P1_TWOWIRE];
	assign level_map[`IEP_SRC_RTC]        = ext_irq_priority_1[`IEP_P1_RTC];
	assign level_map[`IEP_SRC_CONV_WIN]   = ext_irq_priority_1[`IEP_P1_CONV_WIN];
	assign level_map[`IEP_SRC_CONV_DONE]  = ext_irq_priority_1[`IEP_P1_CONV_DONE];
	assign level_map[`IEP_SRC_CNT]        = ext_irq_priority_1[`IEP_P1_CNT];
	assign level_map[`IEP_SRC_CMP0]       = ext_irq_priority_1[`IEP_P1_CMP0];
	assign level_map[`IEP_SRC_REGULATOR]  = ext_irq_priority_2[`IEP_X2_REGULATOR];
	assign level_map[`IEP_SRC_PORT_MATCH] = ext_irq_priority_2[`IEP_X2_PORT_MATCH];

	// Only the two sources whose masks live here are gated
	assign live_req[`IEP_SRC_CMP0:`IEP_SRC_TWOWIRE] = src_req[`IEP_SRC_CMP0:`IEP_SRC_TWOWIRE];
	assign live_req[`IEP_SRC_REGULATOR]  = src_req[`IEP_SRC_REGULATOR]
		& ext_irq_enable_2[`IEP_X2_REGULATOR];
	assign live_req[`IEP_SRC_PORT_MATCH] = src_req[`IEP_SRC_PORT_MATCH]
		& ext_irq_enable_2[`IEP_X2_PORT_MATCH];

	assign hi_req = live_req & level_map;
	assign lo_req = live_req & ~level_map;

	iep_pick u_pick_hi
	(
		.req (hi_req),
		.hit (hi_hit),
		.idx (hi_idx)
	);

	iep_pick u_pick_lo
	(
		.req (lo_req),
		.hit (lo_hit),
		.idx (lo_idx)
	);

	// High may interrupt low service; nothing interrupts high service
	always @*
	begin
		next_irq  = 1'b0;
		next_src  = 3'h0;
		next_high = 1'b0;
		if (!svc_hi && hi_hit)
		begin
			next_irq  = 1'b1;
			next_src  = hi_idx;
			next_high = 1'b1;
		end
		else if (!svc_hi && !svc_lo && lo_hit)
		begin
			next_irq = 1'b1;
			next_src = lo_idx;
		end
	end

	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			core_irq      <= 1'b0;
			core_irq_src  <= 3'h0;
			core_irq_high <= 1'b0;
			src_high      <= `IEP_RST_REG8;
		end
		else
		begin
			core_irq      <= next_irq & ~core_ack;
			core_irq_src  <= next_src;
			core_irq_high <= next_high;
			src_high      <= level_map;
		end
	end

	// Service nesting: ack enters the offered level, return leaves the top one
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			svc_lo <= 1'b0;
			svc_hi <= 1'b0;
		end
		else if (core_ack && core_irq)
		begin
			if (core_irq_high)
				svc_hi <= 1'b1;
			else
				svc_lo <= 1'b1;
		end
		else if (core_reti)
		begin
			if (svc_hi)
				svc_hi <= 1'b0;
			else
				svc_lo <= 1'b0;
		end
	end

	always @*
	begin
		ev_set = `IEP_RST_EV;
		ev_set[`IEP_EV_HI_TAKEN] = core_ack & core_irq & core_irq_high;
		ev_set[`IEP_EV_LO_TAKEN] = core_ack & core_irq & ~core_irq_high;
		ev_set[`IEP_EV_PREEMPT]  = core_ack & core_irq & core_irq_high & svc_lo;
	end

	// AXI4-Lite slave: each write channel held until both address and data are in
	assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	assign do_write = aw_held & w_held & ~s_axi_bvalid;
	assign do_read  = s_axi_arvalid & ~s_axi_rvalid;
	assign w_idx    = aw_addr[`IEP_ADDR_W-1:2];
	assign r_idx    = s_axi_araddr[`IEP_ADDR_W-1:2];
	assign w_ok     = (aw_addr[1:0] == 2'h0) &&
		((w_idx == `IEP_IDX_PRIO1) || (w_idx == `IEP_IDX_EN2) ||
		(w_idx == `IEP_IDX_PRIO2) || (w_idx == `IEP_IDX_MASK));

	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= {`IEP_ADDR_W{1'b0}};
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			else if (do_write)
				aw_held <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			else if (do_write)
				w_held <= 1'b0;
		end
	end

	// Register writes; upper bits of the second pair are not stored
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			ext_irq_priority_1 <= `IEP_RST_REG8;
			ext_irq_enable_2   <= `IEP_RST_X2;
			ext_irq_priority_2 <= `IEP_RST_X2;
			ev_mask            <= `IEP_RST_EV;
		end
		else if (do_write && w_ok && w_strb[0])
		begin
			case (w_idx)
				`IEP_IDX_PRIO1: ext_irq_priority_1 <= w_data[7:0];
				`IEP_IDX_EN2:   ext_irq_enable_2   <= w_data[1:0];
				`IEP_IDX_PRIO2: ext_irq_priority_2 <= w_data[1:0];
				`IEP_IDX_MASK:  ev_mask            <= w_data[`IEP_NEV-1:0];
				default:        ev_mask            <= ev_mask;
			endcase
		end
	end

	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `IEP_RESP_OKAY;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= w_ok ? `IEP_RESP_OKAY : `IEP_RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	always @*
	begin
		rd_word = 32'h0000_0000;
		rd_ok   = (s_axi_araddr[1:0] == 2'h0);
		case (r_idx)
			`IEP_IDX_PRIO1:  rd_word[7:0] = ext_irq_priority_1;
			`IEP_IDX_EN2:    rd_word[1:0] = ext_irq_enable_2;
			`IEP_IDX_PRIO2:  rd_word[1:0] = ext_irq_priority_2;
			`IEP_IDX_STATUS: rd_word[`IEP_NEV-1:0] = ev_status;
			`IEP_IDX_MASK:   rd_word[`IEP_NEV-1:0] = ev_mask;
			`IEP_IDX_REQ:    rd_word[`IEP_NSRC-1:0] = live_req;
			`IEP_IDX_ACTIVE: rd_word[1:0] = {svc_hi, svc_lo};
			default:         rd_ok = 1'b0;
		endcase
	end

	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `IEP_RESP_OKAY;
		end
		else if (do_read)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_ok ? rd_word : 32'h0000_0000;
			s_axi_rresp  <= rd_ok ? `IEP_RESP_OKAY : `IEP_RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// Read clears status; a same-cycle event still lands
	always @(posedge sys_clk)
	begin
		if (rst)
			ev_status <= `IEP_RST_EV;
		else if (do_read && rd_ok && r_idx == `IEP_IDX_STATUS)
			ev_status <= ev_set;
		else
			ev_status <= ev_status | ev_set;
	end

	assign irq = |(ev_status & ev_mask);
endmodule
`default_nettype wire

// *** iep_map.vh ***
`ifndef IEP_MAP_VH
`define IEP_MAP_VH

// Register indices (printed special-function addresses); byte address = index * 4
`define IEP_IDX_PRIO1      8'hF6
`define IEP_IDX_EN2        8'hE7
`define IEP_IDX_PRIO2      8'hF7
`define IEP_IDX_STATUS     8'h40
`define IEP_IDX_MASK       8'h41
`define IEP_IDX_REQ        8'h42
`define IEP_IDX_ACTIVE     8'h43
`define IEP_ADDR_W         10

// Field positions in ext_irq_priority_1
`define IEP_P1_CMP0        5
`define IEP_P1_CNT         4
`define IEP_P1_CONV_DONE   3
`define IEP_P1_CONV_WIN    2
`define IEP_P1_RTC         1
`define IEP_P1_TWOWIRE     0

// Field positions in the second enable / priority pair
`define IEP_X2_PORT_MATCH  1
`define IEP_X2_REGULATOR   0
`define IEP_X2_MASK        8'h03

// Reset values
`define IEP_RST_REG8       8'h00
`define IEP_RST_EV         3'h0
`define IEP_RST_X2         2'h0

// Source numbering on the request vector
`define IEP_NSRC           8
`define IEP_SRC_TWOWIRE    0
`define IEP_SRC_RTC        1
`define IEP_SRC_CONV_WIN   2
`define IEP_SRC_CONV_DONE  3
`define IEP_SRC_CNT        4
`define IEP_SRC_CMP0       5
`define IEP_SRC_REGULATOR  6
`define IEP_SRC_PORT_MATCH 7

// Status / mask event bits
`define IEP_EV_HI_TAKEN    0
`define IEP_EV_LO_TAKEN    1
`define IEP_EV_PREEMPT     2
`define IEP_NEV            3

// AXI responses
`define IEP_RESP_OKAY      2'h0
`define IEP_RESP_SLVERR    2'h2

`endif

// *** iep_pick.v ***
`timescale 1ns/1ps
`default_nettype none
`include "iep_map.vh"

// Lowest-numbered set bit wins; fixed order within one level
module iep_pick
(
	// Candidate vector
	input  wire [`IEP_NSRC-1:0] req,
	// Result
	output reg                  hit,
	output reg  [2:0]           idx
);
	integer i;

	always @*
	begin
		hit = 1'b0;
		idx = 3'h0;
		for (i = `IEP_NSRC - 1; i >= 0; i = i - 1)
		begin
			if (req[i])
			begin
				hit = 1'b1;
				idx = i[2:0];
			end
		end
	end
endmodule
`default_nettype wire

// *** iep_chk_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module iep_chk
(
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        rst,
	// Bus
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Core side
	input wire logic [7:0]  src_req,
	input wire logic        core_ack,
	input wire logic        core_irq,
	input wire logic [2:0]  core_irq_src,
	input wire logic [7:0]  src_high
);
	logic [7:0] req_q;
	always_ff @(posedge sys_clk)
		req_q <= src_req;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
	property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("read answer not held");
	property p_arrdy; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_arrdy: assert property (p_arrdy) else $error("read taken while answer pending");
	property p_awrdy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_awrdy: assert property (p_awrdy) else $error("write taken while answer pending");
	// Own disable so the check runs inside reset
	property p_rst; disable iff (1'b0) rst |=> !core_irq && src_high == 8'h00; endproperty
	a_rst: assert property (p_rst) else $error("reset left state");
	property p_req; core_irq |-> req_q[core_irq_src]; endproperty
	a_req: assert property (p_req) else $error("offer without request");
	property p_ack; core_ack && core_irq |=> !core_irq; endproperty
	a_ack: assert property (p_ack) else $error("offer kept after ack");
	property p_high; !$stable(src_high) |-> $past(s_axi_bvalid) || s_axi_bvalid; endproperty
	a_high: assert property (p_high) else $error("level changed without write");
	c_ack: cover property (core_ack && core_irq);
	c_rd: cover property (s_axi_rvalid && s_axi_rready);
	c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind iep_ctrl iep_chk u_chk
(
	.sys_clk       (sys_clk),
	.rst           (rst),
	.s_axi_awready (s_axi_awready),
	.s_axi_wready  (s_axi_wready),
	.s_axi_bvalid  (s_axi_bvalid),
	.s_axi_bready  (s_axi_bready),
	.s_axi_arready (s_axi_arready),
	.s_axi_rvalid  (s_axi_rvalid),
	.s_axi_rready  (s_axi_rready),
	.s_axi_rdata   (s_axi_rdata),
	.src_req       (src_req),
	.core_ack      (core_ack),
	.core_irq      (core_irq),
	.core_irq_src  (core_irq_src),
	.src_high      (src_high)
);
`default_nettype wire

// *** iep_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module iep_core_model
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// Bench control
	input  wire logic       auto_ack,
	input  wire logic [3:0] ack_wait,
	input  wire logic       reti_go,
	// Block side
	input  wire logic       core_irq,
	output var  logic       core_ack,
	output var  logic       core_reti
);
	logic [3:0] cnt;
	// Ack only from an offer seen at this edge, never outside it
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			core_ack  <= 1'b0;
			core_reti <= 1'b0;
			cnt       <= 4'h0;
		end
		else
		begin
			core_reti <= reti_go;
			core_ack  <= auto_ack && core_irq && !core_ack && cnt == ack_wait;
			cnt       <= (core_irq && !core_ack && cnt != ack_wait) ? cnt + 4'h1 : 4'h0;
		end
	end
endmodule
`default_nettype wire

// *** test_irq_enable_priority_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "iep_map.vh"
module test_irq_enable_priority_regs;
	logic        sys_clk, rst, awvalid, wvalid, arvalid, auto_ack, reti_go, bready, rready;
	logic [9:0]  awaddr, araddr;
	logic [31:0] wdata, d;
	logic [7:0]  src_req;
	logic [3:0]  ack_wait, wstrb;
	logic [1:0]  r;
	wire         awready, wready, bvalid, arready, rvalid, irq;
	wire         core_ack, core_reti, core_irq, core_high;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	wire  [2:0]  core_src;
	wire  [7:0]  src_high;
	int          failures, compares;
	iep_ctrl DUT
	(
		.sys_clk(sys_clk), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.src_req(src_req), .core_ack(core_ack), .core_reti(core_reti),
		.core_irq(core_irq), .core_irq_src(core_src), .core_irq_high(core_high),
		.src_high(src_high), .irq(irq)
	);
	iep_core_model u_core
	(
		.sys_clk(sys_clk), .rst(rst), .auto_ack(auto_ack), .ack_wait(ack_wait),
		.reti_go(reti_go), .core_irq(core_irq), .core_ack(core_ack), .core_reti(core_reti)
	);
	task end_sim;
	begin
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
	begin
		compares++;
		if (g !== e)
		begin
			failures++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	end
	endtask
	// Ready and valid only sampled at edges, so no race with the slave
	task wre(input logic [7:0] i, input logic [31:0] v, input logic [1:0] e);
	begin
		@(posedge sys_clk);
		awaddr  <= {i, 2'b00};
		wdata   <= v;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		chk("bresp", e, bresp);
	end
	endtask
	task wr(input logic [7:0] i, input logic [31:0] v);
	begin
		wre(i, v, `IEP_RESP_OKAY);
	end
	endtask
	task rd(input logic [7:0] i);
	begin
		@(posedge sys_clk);
		araddr  <= {i, 2'b00};
		arvalid <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
	end
	endtask
	task rc(input logic [7:0] i, input logic [31:0] e);
	begin
		rd(i);
		chk("rresp", `IEP_RESP_OKAY, r);
		chk("rdata", e, d);
	end
	endtask
	task wack;
		int n;
	begin
		for (n = 0; n < 40 && core_ack !== 1'b1; n++)
			@(posedge sys_clk);
		chk("core_ack", 1, core_ack);
	end
	endtask
	task rt(input logic [31:0] e);
	begin
		reti_go <= 1'b1;
		@(posedge sys_clk);
		reti_go <= 1'b0;
		rc(`IEP_IDX_ACTIVE, e);
	end
	endtask
	task t_reset;
	begin
		chk("src_high", 0, src_high);
		rc(`IEP_IDX_EN2, 0);
		rc(`IEP_IDX_PRIO2, 0);
		rc(`IEP_IDX_PRIO1, 0);
		rd(8'h01);
		chk("rresp", `IEP_RESP_SLVERR, r);
		chk("rdata", 0, d);
	end
	endtask
	task t_bits;
		int k;
	begin
		wr(`IEP_IDX_EN2, 32'hFFFFFFFF);
		rc(`IEP_IDX_EN2, 32'h3);
		wr(`IEP_IDX_EN2, 0);
		for (k = 0; k < 8; k++)
		begin
			wr(`IEP_IDX_PRIO1, k < 6 ? 1 << k : 8'hC0);
			wr(`IEP_IDX_PRIO2, k < 6 ? 8'hFC : 1 << (k - 6));
			repeat (2) @(posedge sys_clk);
			chk("src_high", 1 << k, src_high);
		end
		rc(`IEP_IDX_PRIO2, 32'h2);
		rc(`IEP_IDX_PRIO1, 32'hC0);
	end
	endtask
	task t_mask;
		int k;
	begin
		for (k = 6; k < 8; k++)
		begin
			wr(`IEP_IDX_EN2, 0);
			src_req <= 8'(1 << k);
			repeat (3) @(posedge sys_clk);
			chk("core_irq", 0, core_irq);
			wr(`IEP_IDX_EN2, 1 << (k - 6));
			repeat (3) @(posedge sys_clk);
			chk("core_irq", 1, core_irq);
			chk("core_src", k, core_src);
			src_req <= 8'h00;
		end
	end
	endtask
	task t_pre;
	begin
		wr(`IEP_IDX_PRIO1, 32'h08);
		wr(`IEP_IDX_MASK, 32'h7);
		rc(`IEP_IDX_STATUS, 0);
		auto_ack <= 1'b1;
		src_req  <= 8'h01;
		wack;
		chk("core_high", 0, core_high);
		src_req  <= 8'h00;
		rc(`IEP_IDX_ACTIVE, 1);
		ack_wait <= 4'h3;
		src_req  <= 8'h08;
		wack;
		chk("core_src", 3, core_src);
		chk("core_high", 1, core_high);
		src_req  <= 8'h00;
		rc(`IEP_IDX_ACTIVE, 3);
		wr(`IEP_IDX_MASK, 0);
		chk("irq", 0, irq);
		wr(`IEP_IDX_MASK, 32'h7);
		chk("irq", 1, irq);
		rc(`IEP_IDX_STATUS, 7);
		rc(`IEP_IDX_STATUS, 0);
		chk("irq", 0, irq);
		rt(1);
		rt(0);
	end
	endtask
	// Slow master: both answers must stand until ready comes
	task t_stall;
	begin
		@(posedge sys_clk);
		{bready, rready} <= 2'b00;
		awaddr  <= {`IEP_IDX_EN2, 2'b00};
		wdata   <= 32'h1;
		araddr  <= {`IEP_IDX_PRIO1, 2'b00};
		{awvalid, wvalid, arvalid} <= 3'b111;
		do
			@(posedge sys_clk);
		while (!(awready && wready && arready));
		{awvalid, wvalid, arvalid} <= 3'b000;
		repeat (4) @(posedge sys_clk);
		chk("bvalid", 1, bvalid);
		chk("rvalid", 1, rvalid);
		{bready, rready} <= 2'b11;
		@(posedge sys_clk);
		chk("bresp", `IEP_RESP_OKAY, bresp);
		chk("rdata", 32'h08, rdata);
		@(posedge sys_clk);
		chk("bvalid", 0, bvalid);
		chk("rvalid", 0, rvalid);
		rc(`IEP_IDX_EN2, 32'h1);
	end
	endtask
	// Refused writes and a write with no strobe bits leave the registers alone
	task t_bus;
	begin
		wstrb <= 4'h0;
		wr(`IEP_IDX_EN2, 32'h2);
		wstrb <= 4'hF;
		rc(`IEP_IDX_EN2, 32'h1);
		wre(`IEP_IDX_STATUS, 32'h7, `IEP_RESP_SLVERR);
		wre(8'h01, 32'h1, `IEP_RESP_SLVERR);
		rc(`IEP_IDX_STATUS, 0);
	end
	endtask
	// Lowest index wins; low held off while low is in service
	task t_order;
	begin
		auto_ack <= 1'b0;
		ack_wait <= 4'h0;
		src_req  <= 8'h83;
		repeat (3) @(posedge sys_clk);
		chk("core_irq", 1, core_irq);
		chk("core_src", 0, core_src);
		chk("core_high", 0, core_high);
		rc(`IEP_IDX_REQ, 32'h03);
		auto_ack <= 1'b1;
		wack;
		auto_ack <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk("core_irq", 0, core_irq);
		src_req  <= 8'h00;
		rt(0);
		chk("irq", 1, irq);
		rc(`IEP_IDX_STATUS, 2);
	end
	endtask
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	// Tests need well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge sys_clk);
		failures++;
		end_sim;
	end
	initial
	begin
		rst = 1'b1;
		{awvalid, wvalid, arvalid, auto_ack, reti_go} = 5'h00;
		{awaddr, araddr, wdata, src_req, ack_wait} = 64'h0;
		{bready, rready} = 2'b11;
		wstrb = 4'hF;
		failures = 0;
		compares = 0;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset;
		t_bits;
		t_mask;
		t_pre;
		t_stall;
		t_bus;
		t_order;
		end_sim;
	end
endmodule
`default_nettype wire
